/* File: dv/tb_peripheral_pin_router.sv */
// Testbench for the peripheral pin router lock block
`timescale 1ns/1ps
`default_nettype none
module tb_peripheral_pin_router;
	import route_lock_pkg::*;
	typedef struct packed {
		logic                          lock;
		logic [N_INPUTS*SEL_WIDTH-1:0]  isel;
		logic [N_OUTPUTS*SEL_WIDTH-1:0] osel;
	} snap_t;
	logic                           i_clk_sys, i_srst, i_por, i_fuse_one_shot, i_sleep, chk, set_used;
	bus_wr_t                        i_bus;
	logic                           o_route_lock_bit;
	logic [N_INPUTS*SEL_WIDTH-1:0]  o_in_sel;
	logic [N_OUTPUTS*SEL_WIDTH-1:0] o_out_sel;
	snap_t                          m;
	snap_t                          q[$];
	int                             n_errors, checks_done, seq, r;
	int                             cyc = 0;

	peripheral_pin_router DUT (.i_clk_sys(i_clk_sys), .i_srst(i_srst), .i_por(i_por),
		.i_fuse_one_shot(i_fuse_one_shot), .i_sleep(i_sleep), .i_bus(i_bus),
		.o_route_lock_bit(o_route_lock_bit), .o_in_sel(o_in_sel), .o_out_sel(o_out_sel));

	initial begin
		i_clk_sys = 1'b0;
		forever #20 i_clk_sys = ~i_clk_sys;
	end

	// ----------------------------------------
	// Driver with reference model
	// ----------------------------------------
	task automatic op(input int k, input int ix, input logic [7:0] d);
		@(posedge i_clk_sys);
		i_bus <= '{wr:1'b1, is_lock:(k == 0), is_in:(k == 1), is_out:(k == 2), idx:4'(ix), data:d};
		i_sleep <= 1'($urandom);
		chk <= 1'b0;
		@(posedge i_clk_sys);
		i_bus.wr <= 1'b0;
		i_sleep <= 1'($urandom);
		chk <= 1'b1;
		if (k == 1 && !m.lock) m.isel[ix*SEL_WIDTH +: SEL_WIDTH] = d[SEL_WIDTH-1:0];
		if (k == 2 && !m.lock) m.osel[ix*SEL_WIDTH +: SEL_WIDTH] = d[SEL_WIDTH-1:0];
		if (k != 0) seq = 0;
		else if (seq == 2) begin
			if (d[0] && !m.lock && !(i_fuse_one_shot && set_used)) begin
				m.lock = 1'b1;
				set_used = 1'b1;
			end else if (!d[0] && m.lock && !(i_fuse_one_shot && set_used))
				m.lock = 1'b0;
			seq = 0;
		end else if (d == KEY_FIRST) seq = 1;
		else if (seq == 1 && d == KEY_SECOND) seq = 2;
		else seq = 0;
		q.push_back(m);
	endtask

	// Software masks interrupts around this, so the three writes are never split
	task automatic keys(input logic v);
		op(0, 0, KEY_FIRST);
		op(0, 0, KEY_SECOND);
		op(0, 0, {7'h00, v});
	endtask

	task automatic rst(input logic por);
		@(posedge i_clk_sys);
		i_srst <= 1'b1;
		i_por <= por;
		chk <= 1'b0;
		repeat (3) @(posedge i_clk_sys);
		i_srst <= 1'b0;
		i_por <= 1'b0;
		chk <= 1'b1;
		m.lock = LOCK_RESET;
		seq = 0;
		set_used = 1'b0;
		if (por) begin
			m.isel = {N_INPUTS{IN_SEL_DEFAULT}};
			m.osel = {N_OUTPUTS{OUT_SEL_DEFAULT}};
		end
		q.push_back(m);
	endtask

	task automatic test_done;
		if (n_errors == 0 && checks_done > 0)
			$display("*** PASS ***");
		else
			$display("*** FAIL ***");
		$finish;
	endtask

	always @(negedge i_clk_sys) begin
		snap_t e;
		if (chk === 1'b1 && q.size() > 0) begin
			e = q.pop_front();
			checks_done++;
			if ({o_route_lock_bit, o_in_sel, o_out_sel} !== e) begin
				n_errors++;
				$display("wrong value at %0t: lock or routing selections differ", $time);
			end
		end
	end

	// Runs take under two thousand cycles; far beyond means a hang
	always @(posedge i_clk_sys) begin
		cyc <= cyc + 1;
		if (cyc == 20000) begin
			n_errors++;
			test_done;
		end
	end

	initial begin
		{i_srst, i_por, i_fuse_one_shot, i_sleep, chk, set_used} = '0;
		i_bus = '0;
		n_errors = 0;
		checks_done = 0;
		seq = 0;
		r = $urandom(32'h3483cebf);
		rst(1'b1);
		op(1, 2, 8'h05);
		keys(1'b1);
		op(1, 2, 8'h09);
		op(2, 7, 8'h1f);
		keys(1'b0);
		op(2, 7, 8'h11);
		op(1, 4, 8'h0c);
		op(2, 4, 8'h0c);
		op(0, 0, KEY_FIRST);
		op(1, 0, 8'h03);
		op(0, 0, KEY_SECOND);
		op(0, 0, 8'h01);
		op(0, 0, KEY_FIRST);
		op(0, 0, KEY_FIRST);
		op(0, 0, 8'hab);
		op(0, 0, 8'h01);
		for (int i = 0; i < 300; i++) begin
			r = $urandom % 8;
			case (r)
				0: keys(1'($urandom));
				1: op(0, 0, 8'($urandom));
				2: rst(1'($urandom));
				default: op(1 + ($urandom % 2), $urandom % 8, 8'($urandom));
			endcase
		end
		keys(1'b0);
		op(1, 3, 8'h07);
		rst(1'b0);
		@(posedge i_clk_sys);
		i_fuse_one_shot <= 1'b1;
		rst(1'b0);
		keys(1'b1);
		keys(1'b0);
		op(1, 1, 8'h04);
		rst(1'b0);
		keys(1'b1);
		// Let the last note be compared before the run ends
		repeat (2) @(posedge i_clk_sys);
		test_done;
	end
endmodule
`default_nettype wire

/* File: hdl/peripheral_pin_router.sv */
// Peripheral pin router lock: routing selections, unlock sequence and one-shot lock
//
// Function
// - While the lock bit is set, writes to every input and output routing selection are ignored.
// - While the lock bit is clear, writes to the input and output routing selections are taken.
// - The lock bit changes only on the write right after 0x55 then 0xaa to the lock control register.
// - With the one-shot fuse set, the lock bit may be cleared once and set once per reset.
// - With the one-shot fuse set, once set again after init the lock bit stays set until reset.
// - Sleep entry or exit never changes a routing selection.
// - Power-on reset returns every routing selection to its default.
// - Any other reset leaves all routing selections unchanged.
`timescale 1ns/1ps
`default_nettype none
module peripheral_pin_router
	import route_lock_pkg::*;
#(
	parameter int N_IN  = route_lock_pkg::N_INPUTS,
	parameter int N_OUT = route_lock_pkg::N_OUTPUTS,
	parameter int SW    = route_lock_pkg::SEL_WIDTH
) (
	input  wire logic                     i_clk_sys,   // System clock, 25 MHz
	input  wire logic                     i_srst,      // Any device reset, sync, high
	input  wire logic                     i_por,       // Power-on reset, sync, high
	input  wire logic                     i_fuse_one_shot, // One-shot lock fuse
	input  wire logic                     i_sleep,     // Device in Sleep
	input  wire route_lock_pkg::bus_wr_t  i_bus,       // Internal bus write
	output logic                          o_route_lock_bit, // Lock state
	output logic [N_IN*SW-1:0]            o_in_sel,    // Input routing selections
	output logic [N_OUT*SW-1:0]           o_out_sel    // Output routing selections
);
	import route_lock_pkg::*;

	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	// The two flags spend the one-shot budget; they are kept even with the fuse
	// intact so that their meaning never depends on when the fuse is read
	typedef struct packed {
		seq_state_t seq;
		logic       lock;
		logic       cleared_once;
		logic       set_once;
	} lock_state_t;

	lock_state_t st_ff;
	lock_state_t nxt_st;
	logic        rst_any;
	logic        lock_wr;
	logic        sel_ok;
	logic        want;
	logic        allow;

	// Either reset restarts the key sequence and refills the one-shot budget;
	// only power-on reaches the selection registers, so other resets keep the map
	assign rst_any = i_srst | i_por;
	assign lock_wr = i_bus.wr & i_bus.is_lock;
	assign want    = i_bus.data[LOCK_BIT_POS];

	// ----------------------------------------------------------------
	// Unlock sequence and lock bit
	// ----------------------------------------------------------------
	always_comb begin
		nxt_st = st_ff;
		allow  = 1'b0;
		if (rst_any) begin
			nxt_st.seq          = SEQ_IDLE;
			nxt_st.lock         = LOCK_RESET;
			nxt_st.cleared_once = 1'b0;
			nxt_st.set_once     = 1'b0;
		end else if (i_bus.wr) begin
			unique case (st_ff.seq)
				SEQ_IDLE: begin
					nxt_st.seq = (lock_wr && i_bus.data == KEY_FIRST) ? SEQ_KEY1 : SEQ_IDLE;
				end
				SEQ_KEY1: begin
					// Wrong value or other target restarts; a fresh first key re-arms
					if (lock_wr && i_bus.data == KEY_SECOND) begin
						nxt_st.seq = SEQ_KEY2;
					end else if (lock_wr && i_bus.data == KEY_FIRST) begin
						nxt_st.seq = SEQ_KEY1;
					end else begin
						nxt_st.seq = SEQ_IDLE;
					end
				end
				SEQ_KEY2: begin
					nxt_st.seq = SEQ_IDLE;
					if (lock_wr) begin
						// One clear and one set per reset when the fuse is blown
						// A set while already locked changes nothing and spends nothing
						// Lock resets clear, so with the fuse blown a clear before the set is a no-op
						if (!i_fuse_one_shot) begin
							allow = 1'b1;
						end else if (want) begin
							allow = !st_ff.set_once;
						end else begin
							allow = !st_ff.cleared_once && !st_ff.set_once;
						end
						if (allow) begin
							nxt_st.lock = want;
							if (want != st_ff.lock && want) begin
								nxt_st.set_once = 1'b1;
							end
							if (want != st_ff.lock && !want) begin
								nxt_st.cleared_once = 1'b1;
							end
						end
					end
				end
				default: nxt_st.seq = SEQ_IDLE;
			endcase
		end
	end

	always_ff @(posedge i_clk_sys) begin
		st_ff <= nxt_st;
	end

	assign o_route_lock_bit = st_ff.lock;

	// ----------------------------------------------------------------
	// Routing selections
	// ----------------------------------------------------------------
	// Sleep is not an input to the write gate, so selections hold through it
	assign sel_ok = i_bus.wr && !st_ff.lock && !rst_any;

	for (genvar g = 0; g < N_IN; g++) begin : g_in
		route_sel_reg #(.W(SW), .RSTV(IN_SEL_DEFAULT[SW-1:0])) u_sel (
			.i_clk_sys (i_clk_sys),
			.i_por     (i_por),
			.i_we      (sel_ok && i_bus.is_in && i_bus.idx == 4'(g)),
			.i_d       (i_bus.data[SW-1:0]),
			.o_q       (o_in_sel[g*SW +: SW])
		);
	end

	for (genvar g = 0; g < N_OUT; g++) begin : g_out
		route_sel_reg #(.W(SW), .RSTV(OUT_SEL_DEFAULT[SW-1:0])) u_sel (
			.i_clk_sys (i_clk_sys),
			.i_por     (i_por),
			.i_we      (sel_ok && i_bus.is_out && i_bus.idx == 4'(g)),
			.i_d       (i_bus.data[SW-1:0]),
			.o_q       (o_out_sel[g*SW +: SW])
		);
	end

	// ----------------------------------------------------------------
	// Checks
	// ----------------------------------------------------------------
	a_locked_hold: assert property (@(posedge i_clk_sys) disable iff (i_por)
		st_ff.lock && !i_srst |=> $stable(o_in_sel) && $stable(o_out_sel))
		else $error("selection changed while locked");
	a_unlocked_write: assert property (@(posedge i_clk_sys) disable iff (rst_any)
		!st_ff.lock && i_bus.wr && i_bus.is_in && i_bus.idx == 4'h0
		|=> o_in_sel[SW-1:0] == $past(i_bus.data[SW-1:0]))
		else $error("unlocked write not taken");
	a_lock_needs_key: assert property (@(posedge i_clk_sys) disable iff (rst_any)
		st_ff.seq != SEQ_KEY2 |=> $stable(st_ff.lock))
		else $error("lock changed without key sequence");
	a_one_shot_set: assert property (@(posedge i_clk_sys) disable iff (rst_any)
		i_fuse_one_shot && st_ff.set_once |-> st_ff.lock)
		else $error("one-shot lock cleared after final set");
	a_one_shot_count: assert property (@(posedge i_clk_sys) disable iff (rst_any)
		i_fuse_one_shot && st_ff.set_once && st_ff.seq == SEQ_KEY2 && lock_wr && !want |=> st_ff.lock)
		else $error("one-shot clear repeated");
	a_sleep_stable: assert property (@(posedge i_clk_sys) disable iff (rst_any)
		$changed(i_sleep) && !i_bus.wr |=> $stable(o_out_sel))
		else $error("sleep changed a selection");
	a_reset_keeps: assert property (@(posedge i_clk_sys)
		i_srst && !i_por |=> $stable(o_in_sel) && $stable(o_out_sel))
		else $error("non power-on reset changed selection");
	a_seq_restart: assert property (@(posedge i_clk_sys) disable iff (rst_any)
		st_ff.seq == SEQ_KEY1 && i_bus.wr && !i_bus.is_lock |=> st_ff.seq == SEQ_IDLE)
		else $error("sequence not restarted");

	// ----------------------------------------------------------------
	// Checks: write gate, key sequence and one-shot budget
	// ----------------------------------------------------------------
	a_sleep_in: assert property (@(posedge i_clk_sys) disable iff (rst_any)
		$changed(i_sleep) && !i_bus.wr |=> $stable(o_in_sel))
		else $error("sleep changed an input selection");
	a_locked_in_drop: assert property (@(posedge i_clk_sys) disable iff (rst_any)
		st_ff.lock && i_bus.wr && i_bus.is_in |=> $stable(o_in_sel))
		else $error("locked input selection write taken");
	a_locked_out_drop: assert property (@(posedge i_clk_sys) disable iff (rst_any)
		st_ff.lock && i_bus.wr && i_bus.is_out |=> $stable(o_out_sel))
		else $error("locked output selection write taken");
	a_unlocked_out: assert property (@(posedge i_clk_sys) disable iff (rst_any)
		!st_ff.lock && i_bus.wr && i_bus.is_out && i_bus.idx == 4'(N_OUT-1)
		|=> o_out_sel[(N_OUT-1)*SW +: SW] == $past(i_bus.data[SW-1:0]))
		else $error("unlocked output write not taken");
	a_unlocked_last_in: assert property (@(posedge i_clk_sys) disable iff (rst_any)
		!st_ff.lock && i_bus.wr && i_bus.is_in && i_bus.idx == 4'(N_IN-1)
		|=> o_in_sel[(N_IN-1)*SW +: SW] == $past(i_bus.data[SW-1:0]))
		else $error("unlocked input write not taken");
	a_key1_arm: assert property (@(posedge i_clk_sys) disable iff (rst_any)
		st_ff.seq == SEQ_IDLE && lock_wr && i_bus.data == KEY_FIRST |=> st_ff.seq == SEQ_KEY1)
		else $error("first key not taken");
	a_key2_arm: assert property (@(posedge i_clk_sys) disable iff (rst_any)
		st_ff.seq == SEQ_KEY1 && lock_wr && i_bus.data == KEY_SECOND |=> st_ff.seq == SEQ_KEY2)
		else $error("second key not taken");
	a_lock_follows: assert property (@(posedge i_clk_sys) disable iff (rst_any)
		st_ff.seq == SEQ_KEY2 && lock_wr && !i_fuse_one_shot |=> st_ff.lock == $past(want))
		else $error("lock write after keys not taken");
	a_key1_idle: assert property (@(posedge i_clk_sys) disable iff (rst_any)
		st_ff.seq == SEQ_KEY1 && !i_bus.wr |=> st_ff.seq == SEQ_KEY1)
		else $error("idle cycle dropped the first key");
	a_key2_done: assert property (@(posedge i_clk_sys) disable iff (rst_any)
		st_ff.seq == SEQ_KEY2 && i_bus.wr |=> st_ff.seq == SEQ_IDLE)
		else $error("sequence not closed after lock write");
	a_wrong_key: assert property (@(posedge i_clk_sys) disable iff (rst_any)
		st_ff.seq == SEQ_KEY1 && lock_wr && i_bus.data != KEY_SECOND && i_bus.data != KEY_FIRST
		|=> st_ff.seq == SEQ_IDLE)
		else $error("wrong second key not refused");
	a_key1_rearm: assert property (@(posedge i_clk_sys) disable iff (rst_any)
		st_ff.seq == SEQ_KEY1 && lock_wr && i_bus.data == KEY_FIRST |=> st_ff.seq == SEQ_KEY1)
		else $error("repeated first key not re-armed");
	a_stray_target: assert property (@(posedge i_clk_sys) disable iff (rst_any)
		st_ff.seq == SEQ_KEY2 && i_bus.wr && !i_bus.is_lock |=> $stable(st_ff.lock))
		else $error("write elsewhere changed the lock");
	a_reset_clears: assert property (@(posedge i_clk_sys)
		rst_any |=> st_ff.lock == LOCK_RESET && st_ff.seq == SEQ_IDLE
		&& !st_ff.set_once && !st_ff.cleared_once)
		else $error("reset did not refill lock state");
	a_one_shot_first: assert property (@(posedge i_clk_sys) disable iff (rst_any)
		i_fuse_one_shot && !st_ff.set_once && st_ff.seq == SEQ_KEY2 && lock_wr && want |=> st_ff.lock)
		else $error("first one-shot set refused");
endmodule
`default_nettype wire

/* File: hdl/route_lock_pkg.sv */
// Package: constants and carrier types of the peripheral pin router lock block
package route_lock_pkg;
	localparam logic [7:0] KEY_FIRST      = 8'h55;
	localparam logic [7:0] KEY_SECOND     = 8'haa;
	localparam int         LOCK_BIT_POS   = 0;
	localparam int         SEL_WIDTH      = 5;
	localparam int         N_INPUTS       = 8;
	localparam int         N_OUTPUTS      = 8;
	localparam logic [SEL_WIDTH-1:0] IN_SEL_DEFAULT  = 5'h00;
	localparam logic [SEL_WIDTH-1:0] OUT_SEL_DEFAULT = 5'h00;
	localparam logic       LOCK_RESET     = 1'b0;

	// Internal bus write toward the block
	typedef struct packed {
		logic                         wr;
		logic                         is_lock;   // Target is the lock control register
		logic                         is_in;     // Target is an input routing selection
		logic                         is_out;    // Target is an output routing selection
		logic [3:0]                   idx;
		logic [7:0]                   data;
	} bus_wr_t;

	typedef enum logic [1:0] {
		SEQ_IDLE = 2'b00,
		SEQ_KEY1 = 2'b01,
		SEQ_KEY2 = 2'b10
	} seq_state_t;
endpackage

/* File: hdl/route_sel_reg.sv */
// One routing selection register, kept across all resets but power-on
`timescale 1ns/1ps
`default_nettype none
module route_sel_reg #(
	parameter int                    W     = 5,
	parameter logic [W-1:0]          RSTV  = '0
) (
	input  wire logic         i_clk_sys,  // System clock
	input  wire logic         i_por,      // Power-on reset
	input  wire logic         i_we,       // Accepted write
	input  wire logic [W-1:0] i_d,        // New selection
	output logic      [W-1:0] o_q         // Current selection
);
	typedef struct packed {
		logic [W-1:0] sel;
	} sel_state_t;

	sel_state_t st_ff;
	sel_state_t nxt_st;

	always_comb begin
		nxt_st = st_ff;
		if (i_por) begin
			nxt_st.sel = RSTV;
		end else if (i_we) begin
			nxt_st.sel = i_d;
		end
	end

	// Only power-on reset is wired here; other resets never reach it
	always_ff @(posedge i_clk_sys) begin
		st_ff <= nxt_st;
	end

	assign o_q = st_ff.sel;

	a_por_default: assert property (@(posedge i_clk_sys) i_por |=> o_q == RSTV)
		else $error("selection not defaulted after power-on reset");
endmodule
`default_nettype wire
